// ==== core/asfc_core.sv ====
`timescale 1ns/100ps
`include "asfc_cfg.svh"

// How it works
// RQ1 - after reset and presence, skip code CCh selects the device directly
// RQ2 - match code 55h then eight id bytes selects only the matching device
// RQ3 - function CCh takes address low, address high, then register data bytes
// RQ4 - page writes and reads step the address by one per byte
// RQ5 - channel mask at 008Bh; set bits join the search, FFh selects all
// RQ6 - polarity after mask; a set bit makes logic one the qualifying state
// RQ7 - control value 04h makes pin a strobe output; readback gives 84h
// RQ8 - source field one takes search condition from activity latches
// RQ9 - control 01h: latch source, or term, pin input, power latch cleared
// RQ10 - writing zero to the power-on latch field clears that latch
// RQ11 - after FFh, FFh, 01h the page reads FFh, FFh, 81h
// RQ12 - function F0h plus address streams register contents to the master
// RQ13 - function F5h samples all eight pins, one status byte per sample
// RQ14 - every 32 status bytes are followed by a two byte crc16
// RQ15 - channel read runs on block after block until a bus reset
// RQ16 - function 5Ah takes byte and inverse; applied only on exact inverse
// RQ17 - output byte FFh turns all drivers off so pins read FFh
// RQ18 - good output write answers AAh, then a fresh pin status byte
// RQ19 - function C3 clears all activity latches and answers AAh
// RQ20 - latch source with or term joins search if any selected latch set
// RQ21 - bad inverse leaves outputs alone and answers ones until reset
// RQ22 - resume code A5h reselects the device addressed most recently
// RQ23 - every byte travels least significant bit first
// RQ24 - a bus reset aborts any function and waits for a rom command
// RQ25 - crc of first block covers command too, later blocks only samples

module asfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clr,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } asfc_fifo_s;

  asfc_fifo_s s;
  asfc_fifo_s next_s;
  logic full;
  logic empty;

  assign empty = (s.wp == s.rp);
  assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s.mem[s.rp[AW-1:0]];

  always_comb begin
    next_s = s;
    if (in_valid && !full) begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      next_s.rp = s.rp + 1'b1;
    end
    if (clr) begin
      next_s.wp = '0;
      next_s.rp = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : asfc_fifo

module asfc_core #(
  parameter logic [63:0] ROM_ID = 64'h0123456789ABCD29 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic bus_reset,
  input wire asfc_pkg::asfc_byte_s rx,
  output logic presence_pulse,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [7:0] pio_in,
  output logic [7:0] pio_o,
  output logic [7:0] pio_oe,
  input wire logic rso_in,
  output logic rso_o,
  output logic rso_oe,
  output logic search_match
);
  import asfc_pkg::*;

  asfc_core_s s;
  asfc_core_s next_s;
  asfc_byte_s push;
  logic in_ready;
  logic accept;
  logic [7:0] qual;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] asfc_crc16(input logic [15:0] c,
                                             input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin // RQ23
        r = (r >> 1) ^ `ASFC_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : asfc_crc16

  function automatic logic [7:0] asfc_reg_rd(input asfc_core_s c,
                                             input logic [15:0] a);
    logic [7:0] ctrl;
    ctrl = 8'h00;
    ctrl[`ASFC_CTRL_SRC] = c.source_select;
    ctrl[`ASFC_CTRL_TERM] = c.ct;
    ctrl[`ASFC_CTRL_PIN_FN] = c.pin_function_select;
    ctrl[`ASFC_CTRL_POR] = c.power_on_latch;
    ctrl[`ASFC_CTRL_SUPPLY] = 1'b1; // RQ7 RQ11
    if (a == `ASFC_ADDR_PIN_STATE) begin
      return c.pin_s2;
    end else if (a == `ASFC_ADDR_OUT_LATCH) begin
      return c.out_latch;
    end else if (a == `ASFC_ADDR_ACTIVITY) begin
      return c.act;
    end else if (a == `ASFC_ADDR_MASK) begin
      return c.mask; // RQ5
    end else if (a == `ASFC_ADDR_POLARITY) begin
      return c.pol; // RQ6
    end else if (a == `ASFC_ADDR_CTRL) begin
      return ctrl;
    end else begin
      return `ASFC_BYTE_ONES;
    end
  endfunction : asfc_reg_rd

  // ----------------------------------------------------------------
  // search condition
  // ----------------------------------------------------------------
  always_comb begin
    if (s.source_select) begin
      qual = s.mask & ~(s.act ^ s.pol); // RQ8
    end else begin
      qual = s.mask & ~(s.pin_s2 ^ s.pol);
    end
  end

  // ----------------------------------------------------------------
  // command interpreter
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    push = '0;
    next_s.strobe = 1'b0;
    next_s.presence = 1'b0;
    next_s.pin_s1 = pio_in;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_prev = s.pin_s2;
    next_s.rs_s1 = rso_in;
    next_s.rs_s2 = s.rs_s1;
    next_s.act = s.act | (s.pin_s2 ^ s.pin_prev);
    if (!s.pin_function_select && !s.rs_s2) begin
      next_s.out_latch = `ASFC_OUT_RESET;
    end
    if (s.ct) begin
      next_s.hit = (qual == s.mask) && (|s.mask);
    end else begin
      next_s.hit = |qual; // RQ20
    end
    case (s.st)
      st_rom: begin
        if (rx.valid) begin
          if (rx.data == `ASFC_CMD_SKIP) begin
            next_s.st = st_func; // RQ1
            next_s.resume = 1'b0;
          end else if (rx.data == `ASFC_CMD_MATCH) begin
            next_s.st = st_match;
            next_s.idx = 3'd0;
            next_s.match_ok = 1'b1;
          end else if (rx.data == `ASFC_CMD_RESUME && s.resume) begin
            next_s.st = st_func; // RQ22
          end else begin
            next_s.st = st_idle;
          end
        end
      end
      st_match: begin
        if (rx.valid) begin
          next_s.match_ok = s.match_ok &&
                            (rx.data == ROM_ID[{s.idx, 3'b000} +: 8]);
          next_s.idx = 3'(s.idx + 3'd1);
          if (s.idx == `ASFC_MATCH_LAST) begin
            next_s.st = next_s.match_ok ? st_func : st_idle; // RQ2
            next_s.resume = next_s.match_ok; // RQ22
          end
        end
      end
      st_func: begin
        if (rx.valid) begin
          next_s.crc = asfc_crc16(16'h0000, rx.data); // RQ25
          next_s.cnt = 5'd0;
          if (rx.data == `ASFC_CMD_RD_REGS) begin
            next_s.st = st_ta1; // RQ12
            next_s.is_write = 1'b0;
          end else if (rx.data == `ASFC_CMD_WR_SEARCH) begin
            next_s.st = st_ta1; // RQ3
            next_s.is_write = 1'b1;
          end else if (rx.data == `ASFC_CMD_CH_READ) begin
            next_s.st = st_car; // RQ13
          end else if (rx.data == `ASFC_CMD_CH_WRITE) begin
            next_s.st = st_cw1;
          end else if (rx.data == `ASFC_CMD_CLR_ACT) begin
            next_s.act = s.pin_s2 ^ s.pin_prev; // RQ19
            next_s.fill = `ASFC_BYTE_CONFIRM;
            next_s.st = st_fill;
          end else begin
            next_s.st = st_idle;
          end
        end
      end
      st_ta1: begin
        if (rx.valid) begin
          next_s.addr[7:0] = rx.data; // RQ3
          next_s.crc = asfc_crc16(s.crc, rx.data);
          next_s.st = st_ta2;
        end
      end
      st_ta2: begin
        if (rx.valid) begin
          next_s.addr[15:8] = rx.data;
          next_s.crc = asfc_crc16(s.crc, rx.data);
          next_s.fill = `ASFC_BYTE_ONES;
          if (s.is_write) begin
            if ({rx.data, s.addr[7:0]} >= `ASFC_ADDR_MASK &&
                {rx.data, s.addr[7:0]} <= `ASFC_ADDR_CTRL) begin
              next_s.st = st_wr;
            end else begin
              next_s.st = st_fill;
            end
          end else if ({rx.data, s.addr[7:0]} >= `ASFC_ADDR_PIN_STATE &&
                       {rx.data, s.addr[7:0]} <= `ASFC_ADDR_PAGE_END) begin
            next_s.st = st_rd;
          end else begin
            next_s.st = st_fill;
          end
        end
      end
      st_rd: begin
        push.valid = 1'b1;
        push.data = asfc_reg_rd(s, s.addr); // RQ12
        if (accept) begin
          next_s.crc = asfc_crc16(s.crc, push.data);
          next_s.addr = s.addr + 16'h0001; // RQ4
          if (s.addr == `ASFC_ADDR_PAGE_END) begin
            next_s.st = st_crc;
            next_s.crc_car = 1'b0;
          end
        end
      end
      st_wr: begin
        if (rx.valid) begin
          next_s.addr = s.addr + 16'h0001; // RQ4
          if (s.addr == `ASFC_ADDR_MASK) begin
            next_s.mask = rx.data; // RQ5
          end else if (s.addr == `ASFC_ADDR_POLARITY) begin
            next_s.pol = rx.data; // RQ6
          end else begin
            next_s.source_select = rx.data[`ASFC_CTRL_SRC]; // RQ9
            next_s.ct = rx.data[`ASFC_CTRL_TERM];
            next_s.pin_function_select = rx.data[`ASFC_CTRL_PIN_FN]; // RQ7
            next_s.power_on_latch = s.power_on_latch & rx.data[`ASFC_CTRL_POR]; // RQ10
            next_s.st = st_fill;
          end
        end
      end
      st_crc: begin
        push.valid = 1'b1;
        push.data = s.cnt[0] ? ~s.crc[15:8] : ~s.crc[7:0];
        if (accept) begin
          next_s.cnt = s.cnt[0] ? 5'd0 : 5'd1;
          if (s.cnt[0]) begin
            next_s.crc = 16'h0000; // RQ25
            next_s.st = s.crc_car ? st_car : st_fill; // RQ15
          end
        end
      end
      st_car: begin
        push.valid = 1'b1;
        push.data = s.pin_s2; // RQ13
        if (accept) begin
          next_s.crc = asfc_crc16(s.crc, push.data);
          next_s.strobe = s.pin_function_select;
          next_s.cnt = 5'(s.cnt + 5'd1);
          if (s.cnt == `ASFC_BLOCK_LAST) begin
            next_s.st = st_crc; // RQ14
            next_s.crc_car = 1'b1;
            next_s.cnt = 5'd0;
          end
        end
      end
      st_cw1: begin
        if (rx.valid) begin
          next_s.cw_byte = rx.data;
          next_s.st = st_cw2;
        end
      end
      st_cw2: begin
        if (rx.valid) begin
          if (rx.data == ~s.cw_byte) begin
            next_s.out_latch = s.cw_byte; // RQ16 RQ17
            next_s.strobe = s.pin_function_select;
            next_s.st = st_cwaa;
          end else begin
            next_s.fill = `ASFC_BYTE_ONES; // RQ21
            next_s.st = st_fill;
          end
        end
      end
      st_cwaa: begin
        push.valid = 1'b1;
        push.data = `ASFC_BYTE_CONFIRM; // RQ18
        if (accept) begin
          next_s.st = st_cwpin;
        end
      end
      st_cwpin: begin
        push.valid = 1'b1;
        push.data = s.pin_s2; // RQ18
        if (accept) begin
          next_s.st = st_cw1;
        end
      end
      st_fill: begin
        push.valid = 1'b1;
        push.data = s.fill;
      end
      default: begin
        next_s.st = st_idle;
      end
    endcase
    if (bus_reset) begin
      next_s.st = st_rom; // RQ24
      next_s.presence = 1'b1;
      push = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
      s.out_latch <= `ASFC_OUT_RESET;
      s.pin_s1 <= `ASFC_PIN_RESET;
      s.pin_s2 <= `ASFC_PIN_RESET;
      s.pin_prev <= `ASFC_PIN_RESET;
      s.rs_s1 <= 1'b1;
      s.rs_s2 <= 1'b1;
      s.power_on_latch <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // answer buffer and pins
  // ----------------------------------------------------------------
  assign accept = push.valid & in_ready;

  asfc_fifo #(
    .WIDTH(`ASFC_BYTE_W),
    .DEPTH(`ASFC_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .clr(bus_reset),
    .in_valid(push.valid),
    .in_data(push.data),
    .in_ready(in_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );

  assign presence_pulse = s.presence;
  assign pio_o = 8'h00;
  assign pio_oe = ~s.out_latch;
  assign rso_o = 1'b0;
  assign rso_oe = s.strobe;
  assign search_match = s.hit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence seq_good_write;
    s.st == st_cw2 && rx.valid && rx.data == ~s.cw_byte && !bus_reset;
  endsequence

  sequence seq_confirm_taken;
    s.st == st_cwaa && accept && !bus_reset;
  endsequence

  chk_skip_select: assert property ( // RQ1
    s.st == st_rom && rx.valid && rx.data == `ASFC_CMD_SKIP && !bus_reset
    |=> s.st == st_func)
    else $error("skip code did not select");

  chk_resume_gate: assert property ( // RQ22
    s.st == st_rom && rx.valid && rx.data == `ASFC_CMD_RESUME &&
    !s.resume && !bus_reset |=> s.st == st_idle)
    else $error("resume accepted without prior address");

  chk_inverse_apply: assert property ( // RQ16
    seq_good_write |=> s.out_latch == $past(s.cw_byte) && s.st == st_cwaa)
    else $error("valid output write not applied");

  chk_inverse_reject: assert property ( // RQ21
    s.st == st_cw2 && rx.valid && rx.data != ~s.cw_byte && !bus_reset &&
    (s.pin_function_select || s.rs_s2) |=> s.st == st_fill && s.fill == 8'hFF &&
    s.out_latch == $past(s.out_latch))
    else $error("bad inverse not rejected");

  chk_confirm_then_pins: assert property ( // RQ18
    seq_good_write ##1 seq_confirm_taken |=> s.st == st_cwpin)
    else $error("pin status did not follow confirm");

  chk_clear_confirm: assert property ( // RQ19
    s.st == st_func && rx.valid && rx.data == `ASFC_CMD_CLR_ACT &&
    !bus_reset |=> s.st == st_fill && s.fill == 8'hAA)
    else $error("latch clear not confirmed");

  chk_block_crc: assert property ( // RQ14
    s.st == st_car && accept && s.cnt == 5'd31 && !bus_reset
    |=> s.st == st_crc && s.crc_car)
    else $error("crc not inserted after 32 samples");

  chk_reset_abort: assert property ( // RQ24
    bus_reset |=> s.st == st_rom && presence_pulse)
    else $error("bus reset did not abort");

  chk_por_clear: assert property ( // RQ10
    s.st == st_wr && rx.valid && s.addr == `ASFC_ADDR_CTRL &&
    !rx.data[3] && !bus_reset |=> !s.power_on_latch)
    else $error("power latch not cleared");

  chk_ctrl_top_bit: assert property ( // RQ11
    s.st == st_rd && s.addr == `ASFC_ADDR_CTRL && !bus_reset
    |-> push.data[7])
    else $error("control top bit not set");

  chk_search_or: assert property ( // RQ20
    s.source_select && !s.ct && |(s.act & s.mask & s.pol) |=> search_match)
    else $error("latch search did not match");
endmodule : asfc_core

// ==== inc/asfc_cfg.svh ====
`ifndef ASFC_CFG_SVH
`define ASFC_CFG_SVH

// ----------------------------------------------------------------
// rom-level and function command codes
// ----------------------------------------------------------------
`define ASFC_CMD_SKIP 8'hCC
`define ASFC_CMD_MATCH 8'h55
`define ASFC_CMD_RESUME 8'hA5
`define ASFC_CMD_WR_SEARCH 8'hCC
`define ASFC_CMD_RD_REGS 8'hF0
`define ASFC_CMD_CH_READ 8'hF5
`define ASFC_CMD_CH_WRITE 8'h5A
`define ASFC_CMD_CLR_ACT 8'hC3

// ----------------------------------------------------------------
// register page addresses
// ----------------------------------------------------------------
`define ASFC_ADDR_PIN_STATE 16'h0088
`define ASFC_ADDR_OUT_LATCH 16'h0089
`define ASFC_ADDR_ACTIVITY 16'h008A
`define ASFC_ADDR_MASK 16'h008B
`define ASFC_ADDR_POLARITY 16'h008C
`define ASFC_ADDR_CTRL 16'h008D
`define ASFC_ADDR_PAGE_END 16'h008F

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define ASFC_CTRL_SRC 0
`define ASFC_CTRL_TERM 1
`define ASFC_CTRL_PIN_FN 2
`define ASFC_CTRL_POR 3
`define ASFC_CTRL_SUPPLY 7

// ----------------------------------------------------------------
// reset values and fixed bytes
// ----------------------------------------------------------------
`define ASFC_OUT_RESET 8'hFF
`define ASFC_PIN_RESET 8'hFF
`define ASFC_BYTE_ONES 8'hFF
`define ASFC_BYTE_CONFIRM 8'hAA
`define ASFC_CRC_POLY 16'hA001
`define ASFC_BLOCK_LAST 5'd31
`define ASFC_MATCH_LAST 3'd7
`define ASFC_FIFO_DEPTH 8
`define ASFC_BYTE_W 8

`endif

// ==== inc/asfc_pkg.sv ====
package asfc_pkg;

  // ----------------------------------------------------------------
  // byte carrier between the bus byte layer and this block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } asfc_byte_s;

  // ----------------------------------------------------------------
  // command interpreter states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_rom, st_match, st_idle, st_func, st_ta1, st_ta2, st_rd, st_wr,
    st_crc, st_car, st_cw1, st_cw2, st_cwaa, st_cwpin, st_fill
  } asfc_state_e;

  typedef struct packed {
    asfc_state_e st;
    logic [15:0] addr;
    logic [15:0] crc;
    logic [4:0] cnt;
    logic [2:0] idx;
    logic match_ok;
    logic resume;
    logic is_write;
    logic crc_car;
    logic [7:0] out_latch;
    logic [7:0] act;
    logic [7:0] mask;
    logic [7:0] pol;
    logic source_select;
    logic ct;
    logic pin_function_select;
    logic power_on_latch;
    logic [7:0] fill;
    logic [7:0] cw_byte;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_prev;
    logic rs_s1;
    logic rs_s2;
    logic strobe;
    logic presence;
    logic hit;
  } asfc_core_s;

endpackage : asfc_pkg

// ==== test/addressable_switch_function_commands_test.sv ====
`timescale 1ns/100ps
module addressable_switch_function_commands_test;
  import asfc_pkg::*;
  localparam logic [63:0] TEST_ID = 64'h5A1C0FFEE0D15E11; // arbitrary value

  `define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    $display("unexpected %s expected %h seen %h", n, e, a); \
    bad_count++; end end

  logic sys_clk, reset, bus_reset, presence_pulse, tx_valid, tx_ready;
  asfc_byte_s rx;
  logic [7:0] tx_data, pio_in, pio_o, pio_oe, ext;
  logic rso_in, rso_o, rso_oe, search_match;
  logic [31:0] lfsr;
  int bad_count, comparisons, strobes;

  // ------------------------------------------------
  // design, master model, pins
  // ------------------------------------------------
  asfc_core #(.ROM_ID(TEST_ID)) DUT (.sys_clk(sys_clk), .reset(reset),
    .bus_reset(bus_reset), .rx(rx), .presence_pulse(presence_pulse),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .pio_in(pio_in), .pio_o(pio_o), .pio_oe(pio_oe), .rso_in(rso_in),
    .rso_o(rso_o), .rso_oe(rso_oe), .search_match(search_match));
  asfc_master_model m (.sys_clk(sys_clk), .bus_reset(bus_reset),
    .rx(rx), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  assign pio_in = (ext & ~pio_oe) | (pio_o & pio_oe);
  assign rso_in = rso_oe ? rso_o : 1'b1;
  always @(negedge sys_clk) if (rso_oe === 1'b1) strobes++;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [7:0] roll();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : roll

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction : crc_step

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic take(output logic [7:0] v);
    logic [7:0] s;
    bit ok;
    s = roll();
    m.get(int'(s[1:0]), v, ok);
    if (!ok) begin
      $display("unexpected tx_valid expected 1 seen 0");
      bad_count++;
      end_sim();
    end
  endtask : take

  task automatic expect_byte(input logic [7:0] e);
    logic [7:0] v;
    take(v);
    `CHK("tx_data", e, v)
  endtask : expect_byte

  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) m.put(q[i]);
  endtask : send

  task automatic bus_rst_chk();
    m.bus_rst();
    #1 `CHK("presence", 1'b1, presence_pulse)
    `CHK("flushed", 1'b0, tx_valid)
  endtask : bus_rst_chk

  // second pair reads back the settled pins
  task automatic pio_write(input logic [7:0] b);
    logic [7:0] s;
    send({b, ~b});
    expect_byte(8'hAA);
    take(s);
    send({b, ~b});
    expect_byte(8'hAA);
    expect_byte(b & ext);
    #1 `CHK("pio_oe", ~b, pio_oe)
  endtask : pio_write

  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    logic [7:0] b;
    logic [15:0] crc;
    reset = 1'b1;
    ext = 8'hFF;
    lfsr = 32'hA5381494;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    #1 `CHK("pio_oe", 8'h00, pio_oe)
    `CHK("drive lows", 9'h000, {pio_o, rso_o})
    `CHK("search", 1'b0, search_match)
    bus_rst_chk();
    m.put(8'h55);
    for (int i = 0; i < 8; i++) m.put(TEST_ID[8*i +: 8] ^ 8'h01);
    send({8'hF0, 8'h8B, 8'h00});
    repeat (20) @(posedge sys_clk);
    #1 `CHK("ignored", 1'b0, tx_valid)
    bus_rst_chk();
    m.put(8'h55);
    for (int i = 0; i < 8; i++) m.put(TEST_ID[8*i +: 8]);
    send({8'hCC, 8'h8B, 8'h00, 8'hFF, 8'hFF, 8'h01});
    bus_rst_chk();
    send({8'hA5, 8'hF0, 8'h8B, 8'h00});
    expect_byte(8'hFF);
    expect_byte(8'hFF);
    expect_byte(8'h81);
    bus_rst_chk();
    send({8'hA5, 8'h5A});
    for (int i = 0; i < 3; i++) begin
      b = roll();
      pio_write(b);
    end
    pio_write(8'hFF);
    b = roll();
    send({b, b ^ 8'h10});
    expect_byte(8'hFF);
    expect_byte(8'hFF);
    #1 `CHK("kept pio_oe", 8'h00, pio_oe)
    bus_rst_chk();
    send({8'hA5, 8'hC3});
    expect_byte(8'hAA);
    repeat (6) @(posedge sys_clk);
    ext <= 8'hF7;
    #1 `CHK("search idle", 1'b0, search_match)
    repeat (8) @(posedge sys_clk);
    #1 `CHK("search hit", 1'b1, search_match)
    bus_rst_chk();
    send({8'hCC, 8'hCC, 8'h8D, 8'h00, 8'h04});
    bus_rst_chk();
    send({8'hCC, 8'hF0, 8'h8D, 8'h00});
    expect_byte(8'h84);
    b = roll();
    ext <= b;
    bus_rst_chk();
    send({8'hCC, 8'hF5});
    crc = crc_step(16'h0000, 8'hF5);
    for (int k = 0; k < 64; k++) begin
      expect_byte(b);
      crc = crc_step(crc, b);
      if (k % 32 == 31) begin
        expect_byte(~crc[7:0]);
        expect_byte(~crc[15:8]);
        crc = 16'h0000;
      end
    end
    expect_byte(b);
    `CHK("pin search", |b, search_match)
    `CHK("strobes", 1'b1, strobes >= 64)
    bus_rst_chk();
    repeat (4) @(posedge sys_clk);
    #1 `CHK("after abort", 1'b0, tx_valid)
    send({8'hA5, 8'hF0, 8'h8B, 8'h00});
    repeat (8) @(posedge sys_clk);
    #1 `CHK("stale resume", 1'b0, tx_valid)
    end_sim();
  end
endmodule : addressable_switch_function_commands_test

// ==== test/asfc_master_model.sv ====
`timescale 1ns/100ps
module asfc_master_model (
  input wire logic sys_clk,
  output logic bus_reset,
  output asfc_pkg::asfc_byte_s rx,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  import asfc_pkg::*;

  // ------------------------------------------------
  // bus master byte layer
  // ------------------------------------------------
  initial begin
    bus_reset = 1'b0;
    rx = '0;
    tx_ready = 1'b0;
  end

  // reset pulse, aborts whatever runs
  task automatic bus_rst();
    @(posedge sys_clk);
    bus_reset <= 1'b1;
    @(posedge sys_clk);
    bus_reset <= 1'b0;
  endtask : bus_rst

  // valid for one cycle; data inverted once released
  task automatic put(input logic [7:0] b);
    @(posedge sys_clk);
    rx <= '{valid: 1'b1, data: b};
    @(posedge sys_clk);
    rx <= '{valid: 1'b0, data: ~b};
  endtask : put

  // read slot, optionally late; takes one byte, gives up after 200 cycles
  task automatic get(input int stall, output logic [7:0] b,
                     output bit ok);
    ok = 1'b0;
    b = 8'h00;
    repeat (stall) @(posedge sys_clk);
    @(posedge sys_clk);
    tx_ready <= 1'b1;
    for (int i = 0; i < 200 && !ok; i++) begin
      #1 ok = (tx_valid === 1'b1);
      b = tx_data;
      @(posedge sys_clk);
    end
    tx_ready <= 1'b0;
  endtask : get
endmodule : asfc_master_model
